// >>> common/mrc_defines.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * magnetometer rate and sensor-reset control block.
 * Assumes a 125 MHz system clock and byte-wide register access.
 */
`ifndef MRC_DEFINES_SVH
`define MRC_DEFINES_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define MRC_ADDR_OUT_FIRST 8'h01
`define MRC_ADDR_OUT_LAST 8'h06
`define MRC_ADDR_OFF_FIRST 8'h09
`define MRC_ADDR_OFF_LAST 8'h0E
`define MRC_ADDR_CTRL1 8'h10
`define MRC_ADDR_CTRL2 8'h11

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define MRC_CTRL1_ACTIVE_BIT 0
`define MRC_CTRL1_AVG_LSB 3
`define MRC_CTRL1_RATE_LSB 5
`define MRC_CTRL2_AUTO_BIT 7
`define MRC_CTRL2_BYPASS_BIT 5
`define MRC_CTRL2_ONESHOT_BIT 4
`define MRC_RATE_RESET 3'h0
`define MRC_AVG_RESET 2'h0
`define MRC_FLAG_RESET 1'b0
`define MRC_AVG_MIN_LOG2 4

// ****************************************************************
// timing
// ****************************************************************
`define MRC_CLK_HZ 125000000
`define MRC_CLK_PERIOD_NS 8
`define MRC_ADC_BASE_HZ 1280
`define MRC_BASE_DIV (`MRC_CLK_HZ / `MRC_ADC_BASE_HZ)
`define MRC_SRST_TIME_NS 1000
`define MRC_SRST_CYCLES ((`MRC_SRST_TIME_NS + `MRC_CLK_PERIOD_NS - 1) / `MRC_CLK_PERIOD_NS)

`endif

// >>> common/mrc_pkg.sv
/*
 * Types shared by the magnetometer control block.
 * Assumes nothing beyond a SystemVerilog elaborator.
 */
`default_nettype none

package mrc_pkg;
    // sequencer states of the acquisition controller
    typedef enum logic [1:0] {
        MRC_IDLE,
        MRC_SRST,
        MRC_ACQ
    } mrc_state_t;
endpackage

`default_nettype wire

// >>> src/mrc_rate_gen.sv
/*
 * Output-rate divider: a 1280 Hz base enable, then a divide by
 * 2^rate times the averaging ratio (16..128).
 * Assumes rate and averaging fields only change in standby.
 */
`default_nettype none

`include "mrc_defines.svh"

module mrc_rate_gen
    import mrc_pkg::*;
#(
    parameter int BASE_DIV = `MRC_BASE_DIV
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic [2:0] rate_select,
    input wire logic [1:0] averaging_select,
    output logic acq_tick
);
    if (BASE_DIV < 2) begin : g_bad_div
        $error("BASE_DIV must be at least 2");
    end

    // ****************************************************************
    // base 1280 Hz enable
    // ****************************************************************
    logic [31:0] base_cnt;
    logic [14:0] period_cnt;
    logic [14:0] period_last;
    logic base_tick;
    logic [3:0] shift_amt;

    assign base_tick = enable && (base_cnt == 32'(BASE_DIV - 1));
    // period in base ticks is 2^(rate + 4 + avg)
    assign shift_amt = 4'(rate_select) + 4'(averaging_select) + 4'(`MRC_AVG_MIN_LOG2);
    assign period_last = 15'((32'h0000_0001 << shift_amt) - 32'h0000_0001);
    assign acq_tick = base_tick && (period_cnt == period_last);

    // counters hold at zero in standby so a new start is clean
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            base_cnt <= 32'h0000_0000;
            period_cnt <= 15'h0000;
        end else if (!enable) begin
            base_cnt <= 32'h0000_0000;
            period_cnt <= 15'h0000;
        end else if (base_tick) begin
            base_cnt <= 32'h0000_0000;
            period_cnt <= acq_tick ? 15'h0000 : period_cnt + 15'h0001;
        end else begin
            base_cnt <= base_cnt + 32'h0000_0001;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    // helper: base ticks seen since the last output tick
    logic [15:0] ticks_seen;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ticks_seen <= 16'h0000;
        end else if (!enable || acq_tick) begin
            ticks_seen <= 16'h0000;
        end else if (base_tick) begin
            ticks_seen <= ticks_seen + 16'h0001;
        end
    end

    chk_output_period: assert property (@(posedge clk) disable iff (!rst_n)
        acq_tick |-> (32'(ticks_seen) + 32'h0000_0001) == (32'h0000_0001 << shift_amt))
        else $error("output tick not at 2^rate times averaging ratio");
    cov_fast_rate: cover property (@(posedge clk) disable iff (!rst_n)
        acq_tick && rate_select == 3'h0 && averaging_select == 2'h0);
endmodule // mrc_rate_gen

`default_nettype wire

// >>> src/mrc_sensor_reset.sv
/*
 * Magnetic sensor reset pulse timer: a start pulse drives the
 * reset coil for a fixed number of cycles, with a done pulse on the last one.
 * Assumes start is only given while idle.
 */
`default_nettype none

`include "mrc_defines.svh"

module mrc_sensor_reset
    import mrc_pkg::*;
#(
    parameter int CYCLES = `MRC_SRST_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    output logic busy,
    output logic done
);
    if (CYCLES < 1 || CYCLES > 65535) begin : g_bad_cycles
        $error("CYCLES must lie in 1..65535");
    end

    logic [15:0] cnt;

    // last cycle of the coil pulse
    assign done = busy && (cnt == 16'(CYCLES - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            cnt <= 16'h0000;
        end else if (start && !busy) begin
            busy <= 1'b1;
            cnt <= 16'h0000;
        end else if (done) begin
            busy <= 1'b0;
        end else if (busy) begin
            cnt <= cnt + 16'h0001;
        end
    end

    // helper: length of the current pulse
    logic [15:0] len;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            len <= 16'h0000;
        end else begin
            len <= busy ? len + 16'h0001 : 16'h0000;
        end
    end

    chk_pulse_length: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(busy) |-> $past(len) == 16'(CYCLES - 1))
        else $error("sensor reset pulse has wrong length");
endmodule // mrc_sensor_reset

`default_nettype wire

// >>> src/mrc_top.sv
/*
 * Magnetometer rate and sensor-reset control: control registers,
 * output-rate timing, one-shot and automatic sensor reset cycles,
 * and user offset correction of the measured axes.
 * Assumes the serial front end turns host transfers into one-cycle
 * byte read and write strobes, and that the measurement front end
 * answers each request with one averaged sample per axis.
 */
// Summary of operation
// - sample rate is 1280 over 2^rate over ratio
// - auto enable runs reset before every acquisition
// - auto enable bit always reads back zero
// - bypass zero adds user offsets to data
// - bypass one stores uncorrected data
// - factory trim always applied to output data
// - writing one-shot bit starts sensor reset cycle
// - one-shot bit reads one while cycle runs
// - one-shot bit clears itself when cycle ends
// - control flags are zero after reset
// - rate and averaging fields reset to zero
// - offsets added in two's complement, no clipping
`default_nettype none

`include "mrc_defines.svh"

module mrc_top
    import mrc_pkg::*;
#(
    parameter int BASE_DIV = `MRC_BASE_DIV,
    parameter int SRST_CYCLES = `MRC_SRST_CYCLES,
    parameter logic [47:0] FACT_TRIM = 48'h0000_0000_0000 // arbitrary trim, z:y:x
) (
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR_EN,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD_EN,
    output logic [7:0] REG_RDATA,
    output logic MEAS_REQ,
    input wire logic MEAS_VALID,
    input wire logic [15:0] MEAS_X,
    input wire logic [15:0] MEAS_Y,
    input wire logic [15:0] MEAS_Z,
    output logic SENSOR_RESET_ACTIVE,
    output logic DATA_READY
);
    // ****************************************************************
    // reset release
    // ****************************************************************
    logic rst_meta;
    logic rst_n;

    // async assert, release through two flops
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ****************************************************************
    // register decode
    // ****************************************************************
    logic [2:0] rate_select;
    logic [1:0] averaging_select;
    logic active;
    logic auto_sensor_reset_enable;
    logic offset_bypass;
    logic one_shot;
    logic [7:0] off_reg [6];
    logic [7:0] out_reg [6];

    logic wr_ctrl1;
    logic wr_ctrl2;
    logic wr_off;
    logic rd_out;
    logic rd_off;
    logic [2:0] off_idx;
    logic [2:0] out_idx;
    logic oneshot_write;

    assign wr_ctrl1 = REG_WR_EN && (REG_ADDR == `MRC_ADDR_CTRL1);
    assign wr_ctrl2 = REG_WR_EN && (REG_ADDR == `MRC_ADDR_CTRL2);
    assign wr_off = REG_WR_EN && (REG_ADDR >= `MRC_ADDR_OFF_FIRST)
        && (REG_ADDR <= `MRC_ADDR_OFF_LAST);
    assign rd_out = (REG_ADDR >= `MRC_ADDR_OUT_FIRST) && (REG_ADDR <= `MRC_ADDR_OUT_LAST);
    assign rd_off = (REG_ADDR >= `MRC_ADDR_OFF_FIRST) && (REG_ADDR <= `MRC_ADDR_OFF_LAST);
    assign off_idx = 3'(REG_ADDR - `MRC_ADDR_OFF_FIRST);
    assign out_idx = 3'(REG_ADDR - `MRC_ADDR_OUT_FIRST);
    assign oneshot_write = wr_ctrl2 && REG_WDATA[`MRC_CTRL2_ONESHOT_BIT];

    // read mux: write-only and unused bits return zero
    logic [7:0] ctrl1_view;
    logic [7:0] ctrl2_view;
    logic [7:0] rd_mux;

    assign ctrl1_view = {rate_select, averaging_select, 2'b00, active};
    assign ctrl2_view = {1'b0, 1'b0, offset_bypass, one_shot, 4'h0};
    assign rd_mux = rd_out ? out_reg[out_idx]
        : rd_off ? off_reg[off_idx]
        : (REG_ADDR == `MRC_ADDR_CTRL1) ? ctrl1_view
        : (REG_ADDR == `MRC_ADDR_CTRL2) ? ctrl2_view
        : 8'h00;

    // ****************************************************************
    // control registers
    // ****************************************************************
    mrc_state_t state;
    mrc_state_t next_state;
    logic srst_done;
    logic srst_is_oneshot;
    logic next_one_shot;

    // a new write of one wins over the self-clear of the same cycle
    assign next_one_shot = oneshot_write
        || (one_shot && !(srst_done && srst_is_oneshot));

    // rate fields are taken as written; the host keeps them to standby
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rate_select <= `MRC_RATE_RESET;
            averaging_select <= `MRC_AVG_RESET;
            active <= `MRC_FLAG_RESET;
            auto_sensor_reset_enable <= `MRC_FLAG_RESET;
            offset_bypass <= `MRC_FLAG_RESET;
            one_shot <= `MRC_FLAG_RESET;
        end else begin
            if (wr_ctrl1) begin
                rate_select <= REG_WDATA[`MRC_CTRL1_RATE_LSB +: 3];
                averaging_select <= REG_WDATA[`MRC_CTRL1_AVG_LSB +: 2];
                active <= REG_WDATA[`MRC_CTRL1_ACTIVE_BIT];
            end
            if (wr_ctrl2) begin
                auto_sensor_reset_enable <= REG_WDATA[`MRC_CTRL2_AUTO_BIT];
                offset_bypass <= REG_WDATA[`MRC_CTRL2_BYPASS_BIT];
            end
            one_shot <= next_one_shot;
        end
    end

    // offset registers; the low byte's bit 0 is forced to zero
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            off_reg <= '{default: 8'h00};
        end else if (wr_off) begin
            off_reg[off_idx] <= off_idx[0] ? {REG_WDATA[7:1], 1'b0} : REG_WDATA;
        end
    end

    // read data is registered one cycle after the read strobe
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD_EN) begin
            REG_RDATA <= rd_mux;
        end
    end

    // ****************************************************************
    // rate timing and sensor reset timer
    // ****************************************************************
    logic acq_tick;
    logic acq_pend;
    logic srst_start;
    logic go_acq;
    logic acq_take;

    mrc_rate_gen #(
        .BASE_DIV(BASE_DIV)
    ) u_rate (
        .clk(SYS_CLK),
        .rst_n(rst_n),
        .enable(active),
        .rate_select(rate_select),
        .averaging_select(averaging_select),
        .acq_tick(acq_tick)
    );

    mrc_sensor_reset #(
        .CYCLES(SRST_CYCLES)
    ) u_srst (
        .clk(SYS_CLK),
        .rst_n(rst_n),
        .start(srst_start),
        .busy(SENSOR_RESET_ACTIVE),
        .done(srst_done)
    );

    // ****************************************************************
    // acquisition sequencer
    // ****************************************************************
    logic idle;
    assign idle = (state == MRC_IDLE);
    // one-shot requests take priority over a waiting acquisition
    assign srst_start = idle && (one_shot || (acq_pend && auto_sensor_reset_enable));
    assign acq_take = idle && !one_shot && acq_pend;
    assign go_acq = (acq_take && !auto_sensor_reset_enable)
        || (state == MRC_SRST && srst_done && !srst_is_oneshot);

    always_comb begin
        next_state = state;
        case (state)
            MRC_IDLE: begin
                if (srst_start) begin
                    next_state = MRC_SRST;
                end else if (go_acq) begin
                    next_state = MRC_ACQ;
                end
            end
            MRC_SRST: begin
                if (srst_done) begin
                    next_state = srst_is_oneshot ? MRC_IDLE : MRC_ACQ;
                end
            end
            MRC_ACQ: begin
                if (MEAS_VALID) begin
                    next_state = MRC_IDLE;
                end
            end
            default: begin
                next_state = MRC_IDLE;
            end
        endcase
    end

    // a tick during a busy spell is kept, never dropped
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= MRC_IDLE;
            acq_pend <= 1'b0;
            srst_is_oneshot <= 1'b0;
            MEAS_REQ <= 1'b0;
        end else begin
            state <= next_state;
            acq_pend <= acq_tick || (acq_pend && !acq_take);
            if (srst_start) begin
                srst_is_oneshot <= one_shot;
            end
            MEAS_REQ <= go_acq;
        end
    end

    // ****************************************************************
    // data path: factory trim, then optional user offset
    // ****************************************************************
    logic [15:0] meas [3];
    logic [15:0] cal [3];
    logic [15:0] corr [3];
    logic store;

    assign meas[0] = MEAS_X;
    assign meas[1] = MEAS_Y;
    assign meas[2] = MEAS_Z;
    assign store = (state == MRC_ACQ) && MEAS_VALID;

    for (genvar a = 0; a < 3; a++) begin : g_axis
        // plain modular sums: no clipping by design
        assign cal[a] = meas[a] + FACT_TRIM[16 * a +: 16];
        assign corr[a] = offset_bypass ? cal[a]
            : cal[a] + {off_reg[2 * a], off_reg[2 * a + 1]};

        always_ff @(posedge SYS_CLK or negedge rst_n) begin
            if (!rst_n) begin
                out_reg[2 * a] <= 8'h00;
                out_reg[2 * a + 1] <= 8'h00;
            end else if (store) begin
                out_reg[2 * a] <= corr[a][15:8];
                out_reg[2 * a + 1] <= corr[a][7:0];
            end
        end
    end

    // new sample flag for the host side
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            DATA_READY <= 1'b0;
        end else begin
            DATA_READY <= store;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    logic ctrl2_read;
    assign ctrl2_read = REG_RD_EN && (REG_ADDR == `MRC_ADDR_CTRL2);

    chk_auto_reads_zero: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        ctrl2_read |=> !REG_RDATA[`MRC_CTRL2_AUTO_BIT])
        else $error("auto enable bit read back nonzero");
    chk_unused_zero: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        ctrl2_read |=> REG_RDATA[6] == 1'b0 && REG_RDATA[3:0] == 4'h0)
        else $error("unused bits of second register read nonzero");
    chk_oneshot_busy_read: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        ctrl2_read && SENSOR_RESET_ACTIVE && srst_is_oneshot
            |=> REG_RDATA[`MRC_CTRL2_ONESHOT_BIT])
        else $error("one-shot bit not reading one while cycle runs");
    chk_oneshot_clear: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        $fell(one_shot) |-> $past(srst_done) && $past(srst_is_oneshot))
        else $error("one-shot bit cleared without end of cycle");
    chk_oneshot_start: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        oneshot_write && idle && !go_acq |=> ##[0:1] SENSOR_RESET_ACTIVE)
        else $error("one-shot write did not start a reset cycle");
    chk_auto_before_acq: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        MEAS_REQ && $past(auto_sensor_reset_enable)
            |-> $past(state) == MRC_SRST && $past(srst_done))
        else $error("auto acquisition without a finished reset cycle");
    chk_no_auto_direct: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        acq_take && !auto_sensor_reset_enable |=> MEAS_REQ && !SENSOR_RESET_ACTIVE)
        else $error("acquisition with auto reset off did not start directly");
    chk_corrected_store: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        store && !offset_bypass |=> {out_reg[0], out_reg[1]}
            == $past(MEAS_X + FACT_TRIM[15:0] + {off_reg[0], off_reg[1]}))
        else $error("corrected x value wrong");
    chk_raw_store: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        store && offset_bypass |=> {out_reg[4], out_reg[5]} == $past(MEAS_Z + FACT_TRIM[47:32]))
        else $error("raw z value wrong");
    chk_reset_values: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        $rose(rst_n) |-> ctrl1_view == 8'h00 && !auto_sensor_reset_enable
            && !offset_bypass && !one_shot)
        else $error("control fields not zero after reset");

    cov_oneshot_done: cover property (@(posedge SYS_CLK) disable iff (!rst_n)
        $fell(one_shot));
    cov_auto_acq: cover property (@(posedge SYS_CLK) disable iff (!rst_n)
        srst_done && !srst_is_oneshot ##1 MEAS_REQ);
    cov_raw_store: cover property (@(posedge SYS_CLK) disable iff (!rst_n)
        store && offset_bypass);
endmodule // mrc_top

`default_nettype wire

// >>> sim/mrc_front_model.sv
/*
 * Measurement front end model: answers each request with one
 * averaged sample per axis after a fixed latency.
 * Assumes requests are one-cycle pulses from the control block.
 */
`default_nettype none

module mrc_front_model #(
    parameter int LAT = 5,
    parameter logic [15:0] DX = 16'h7FF0,
    parameter logic [15:0] DY = 16'h0001,
    parameter logic [15:0] DZ = 16'h0100
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req,
    output logic valid,
    output logic [15:0] x,
    output logic [15:0] y,
    output logic [15:0] z
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;

    // countdown from request to answer
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            valid <= 1'b0;
        end else begin
            valid <= (cnt == 1);
            if (req) begin
                cnt <= LAT;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end

    // lines show inverted data off the strobe, so stale values never match
    assign x = valid ? DX : ~DX;
    assign y = valid ? DY : ~DY;
    assign z = valid ? DZ : ~DZ;
endmodule // mrc_front_model

`default_nettype wire

// >>> sim/tb_mrc_top.sv
/*
 * Self-checking bench of the rate and sensor-reset control block.
 * Assumes the front end model answers every request after a delay.
 */
`default_nettype none

module tb_mrc_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BDIV = 4;
    localparam int SRST = 3;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic wen = 1'b0;
    logic ren = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdat = 8'h00;
    logic [7:0] rdat;
    logic req, vld, srst, data_rdy;
    logic [15:0] mx, my, mz;
    logic [7:0] cur = 8'h00;
    logic [7:0] offb [6] = '{8'h00, 8'h21, 8'hFF, 8'hFF, 8'h12, 8'h35};
    int mismatches = 0;
    int n_compared = 0;
    int srst_cyc = 0;
    int n;

    mrc_top #(.BASE_DIV(BDIV), .SRST_CYCLES(SRST), .FACT_TRIM(48'h0003_0002_0001)) u_dut (
        .SYS_CLK(clk), .ARST_N(arst_n), .REG_ADDR(addr), .REG_WR_EN(wen),
        .REG_WDATA(wdat), .REG_RD_EN(ren), .REG_RDATA(rdat), .MEAS_REQ(req),
        .MEAS_VALID(vld), .MEAS_X(mx), .MEAS_Y(my), .MEAS_Z(mz),
        .SENSOR_RESET_ACTIVE(srst), .DATA_READY(data_rdy));

    mrc_front_model u_fe (.clk(clk), .rst_n(arst_n), .req(req), .valid(vld),
        .x(mx), .y(my), .z(mz));

    // clock and coil-drive cycle counter
    always #4 clk = ~clk;
    always @(posedge clk) begin
        if (srst === 1'b1) begin
            srst_cyc++;
        end
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wen <= 1'b1;
        @(posedge clk);
        wen <= 1'b0;
    endtask

    // read data lands on the edge that takes the strobe
    task rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        ren <= 1'b1;
        @(posedge clk);
        ren <= 1'b0;
        #1;
        chk({8'h00, rdat}, {8'h00, exp});
    endtask

    // bounded wait for the data-ready pulse, n counts edges
    task wait_ready;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (data_rdy !== 1'b1 && n < 20000);
        chk({15'h0000, data_rdy}, 16'h0001);
    endtask

    task per_chk(input int exp_n, input int exp_srst);
        wait_ready;
        srst_cyc = 0;
        wait_ready;
        chk(16'(n), 16'(exp_n));
        chk(16'(srst_cyc), 16'(exp_srst));
    endtask

    // standby first and let any acquisition drain, then retune
    task set_rate(input logic [2:0] r, input logic [1:0] a);
        wr(8'h10, {cur[7:1], 1'b0});
        repeat (20) @(posedge clk);
        cur = {r, a, 3'b001};
        wr(8'h10, {r, a, 3'b000});
        wr(8'h10, cur);
    endtask

    task out_chk(input logic [15:0] ex, input logic [15:0] ey, input logic [15:0] ez);
        rdc(8'h01, ex[15:8]);
        rdc(8'h02, ex[7:0]);
        rdc(8'h03, ey[15:8]);
        rdc(8'h04, ey[7:0]);
        rdc(8'h05, ez[15:8]);
        rdc(8'h06, ez[7:0]);
    endtask

    task finish_test;
        $display("compared=%0d mismatches=%0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rdc(8'h10, 8'h00);
        rdc(8'h11, 8'h00);
        wr(8'h20, 8'hFF);
        rdc(8'h20, 8'h00);
        wr(8'h10, 8'hE6);
        rdc(8'h10, 8'hE0);
        cur = 8'hE0;
        srst_cyc = 0;
        wr(8'h11, 8'hFF);
        rdc(8'h11, 8'h30);
        repeat (8) @(posedge clk);
        rdc(8'h11, 8'h20);
        chk(16'(srst_cyc), 16'(SRST));
        for (int i = 0; i < 6; i++) begin
            wr(8'(8'h09 + i), offb[i]);
        end
        wr(8'h11, 8'h00);
        set_rate(3'd0, 2'd0);
        per_chk(BDIV << 4, 0);
        out_chk(16'h8011, 16'h0001, 16'h1337);
        wr(8'h11, 8'h20);
        wait_ready;
        out_chk(16'h7FF1, 16'h0003, 16'h0103);
        wr(8'h11, 8'hA0);
        // let a sample decided before the enable pass, so both ends of the period see a reset
        wait_ready;
        per_chk(BDIV << 4, SRST);
        rdc(8'h11, 8'h20);
        wr(8'h11, 8'h00);
        for (int r = 0; r < 8; r++) begin
            set_rate(3'(r), 2'd0);
            per_chk(BDIV << (r + 4), 0);
        end
        for (int a = 1; a < 4; a++) begin
            set_rate(3'd0, 2'(a));
            per_chk(BDIV << (a + 4), 0);
        end
        finish_test;
    end

    // watchdog well beyond the longest expected run
    initial begin
        #800000;
        mismatches++;
        finish_test;
    end
endmodule // tb_mrc_top

`default_nettype wire
